/* hdl/ssgt_port.sv */
// sync serial port: gated-clock and network slot transfer logic
`default_nettype none
`timescale 1ns/10ps
module ssgt_port #(
    parameter int QDEPTH_P = ssgt_pkg::QDEPTH
) (
    input wire logic REF_CLK_IN, // 50 MHz system clock
    input wire logic RST_IN, // sync reset, active high
    input wire ssgt_pkg::ssgt_pin_in_t PINS_IN, // serial pins in
    output var ssgt_pkg::ssgt_pin_out_t PINS_OUT, // serial pins out
    input wire logic [7:0] ADDR_IN, // register byte address
    input wire logic [31:0] WDATA_IN, // write data
    input wire logic WR_IN, // write strobe
    input wire logic RD_IN, // read strobe
    output var logic [31:0] RDATA_OUT, // read data, cycle after strobe
    output var logic TX_IRQ_OUT, // transmit interrupt, high active
    output var logic RX_IRQ_OUT // receive interrupt, high active
);
    import ssgt_pkg::*;

    ssgt_state_t s;
    ssgt_state_t n;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] p_lvl;
    logic [PIN_W-1:0] p_rise;
    logic [PIN_W-1:0] p_fall;
    ssgt_pin_in_t lvl;
    ssgt_pin_in_t rise;
    ssgt_pin_in_t fall;

    ssgt_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .din_in(PINS_IN),
        .lvl_out(p_lvl),
        .rise_out(p_rise),
        .fall_out(p_fall)
    );

    assign lvl = ssgt_pin_in_t'(p_lvl);
    assign rise = ssgt_pin_in_t'(p_rise);
    assign fall = ssgt_pin_in_t'(p_fall);

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    logic port_en;
    logic tx_en;
    logic rx_en;
    logic gated;
    logic use_int;
    logic tqen;
    logic rqen;
    logic [BCNT_W-1:0] wl;
    logic [SLOT_W-1:0] slot_fld;
    logic [SLOT_W-1:0] last_slot;
    logic [QLVL_W-1:0] twm;
    logic [QLVL_W-1:0] rwm;
    logic [DIV_W-1:0] divv;

    assign port_en = s.ctrl[C_PORT];
    assign tx_en = s.ctrl[C_TXEN];
    assign rx_en = s.ctrl[C_RXEN];
    assign gated = s.ctrl[C_GATED];
    assign use_int = gated && s.ctrl[C_INTCLK];
    assign tqen = s.ctrl[C_TQEN];
    assign rqen = s.ctrl[C_RQEN];
    assign wl = s.ctrl[C_WL +: BCNT_W];
    assign slot_fld = s.ctrl[C_SLOTS +: SLOT_W];
    assign last_slot = (slot_fld < SLOT_MIN) ? SLOT_MIN : slot_fld;
    assign twm = s.cfg[F_TXWM +: QLVL_W];
    assign rwm = s.cfg[F_RXWM +: QLVL_W];
    assign divv = s.cfg[F_DIV +: DIV_W];

    // ------------------------------------------------------------
    // register strobes
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_stat;
    logic wr_hold;
    logic wr_skip;
    logic wr_cfg;
    logic rd_rx;

    assign wr_ctrl = WR_IN && ADDR_IN == OFF_CTRL;
    assign wr_stat = WR_IN && ADDR_IN == OFF_STAT;
    assign wr_hold = WR_IN && ADDR_IN == OFF_TXHOLD;
    assign wr_skip = WR_IN && ADDR_IN == OFF_TXSKIP;
    assign wr_cfg = WR_IN && ADDR_IN == OFF_CFG;
    assign rd_rx = RD_IN && ADDR_IN == OFF_RXHOLD;

    // ------------------------------------------------------------
    // queues
    // ------------------------------------------------------------
    logic tq_pop;
    logic tq_full;
    logic tq_empty;
    logic [DATA_W-1:0] tq_dout;
    logic [QLVL_W-1:0] tq_lvl;
    logic rq_push;
    logic rq_full;
    logic rq_empty;
    logic [DATA_W-1:0] rq_dout;
    logic [QLVL_W-1:0] rq_lvl;
    logic [DATA_W-1:0] rx_word;

    ssgt_queue #(
        .W(DATA_W),
        .DEPTH(QDEPTH_P),
        .LW(QLVL_W)
    ) u_txq (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .flush_in(!tqen),
        .push_in(wr_hold && tqen),
        .pop_in(tq_pop),
        .din_in(WDATA_IN[DATA_W-1:0]),
        .dout_out(tq_dout),
        .level_out(tq_lvl),
        .full_out(tq_full),
        .empty_out(tq_empty)
    );

    ssgt_queue #(
        .W(DATA_W),
        .DEPTH(QDEPTH_P),
        .LW(QLVL_W)
    ) u_rxq (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .flush_in(!rqen),
        .push_in(rq_push),
        .pop_in(rd_rx && rqen),
        .din_in(rx_word),
        .dout_out(rq_dout),
        .level_out(rq_lvl),
        .full_out(rq_full),
        .empty_out(rq_empty)
    );

    // ------------------------------------------------------------
    // bit clock events
    // ------------------------------------------------------------
    logic int_tick;
    logic vbound;
    logic pending;
    logic gate_nx;
    logic t_rise;
    logic t_fall;
    logic r_fall;

    // the word timer runs even while gated off, so gaps are whole words
    assign int_tick = use_int && s.div == divv;
    assign vbound = int_tick && !s.ph && s.vbit == '0;
    assign pending = port_en && tx_en && (tqen ? !tq_empty : s.tx_wr);
    assign gate_nx = vbound ? pending : s.gate;
    assign t_rise = use_int ? (int_tick && !s.ph && gate_nx) : rise.tx_bclk;
    assign t_fall = use_int ? (int_tick && s.ph && s.gate) : fall.tx_bclk;
    assign r_fall = gated ? t_fall : fall.rx_bclk;

    // ------------------------------------------------------------
    // word and frame boundaries
    // ------------------------------------------------------------
    logic t_frame;
    logic [BCNT_W-1:0] t_idx;
    logic t_bound;
    logic t_on;
    logic t_run;
    logic tx_load;
    logic [DATA_W-1:0] ld_word;
    logic r_frame;
    logic [BCNT_W-1:0] r_idx;
    logic r_on;
    logic r_wclk;
    logic [DATA_W-1:0] rx_mask;
    logic [DATA_W-1:0] rx_shn;

    assign t_frame = t_rise && s.tx_fs_pend && !gated;
    assign t_idx = t_frame ? '0 : s.tx_bit;
    assign t_bound = t_rise && t_idx == '0;
    assign t_on = port_en && (gated || s.tx_on || (t_frame && tx_en));
    assign t_run = t_bound && t_on && tx_en;
    assign tx_load = t_run && (gated || !s.tx_skip);
    assign tq_pop = tx_load && tqen;
    assign ld_word = (tqen && !tq_empty) ? tq_dout : s.tx_hold;

    assign r_frame = r_fall && s.rx_fs_pend && !gated;
    assign r_idx = r_frame ? '0 : s.rx_bit;
    assign r_on = port_en && (gated || s.rx_on || (r_frame && rx_en));
    assign r_wclk = r_fall && r_on && rx_en && r_idx == wl;
    assign rx_mask = {DATA_W{1'b1}} >> (WL_MAX - wl);
    assign rx_shn = {s.rx_sh[DATA_W-2:0], lvl.rx_data};
    assign rx_word = rx_shn & rx_mask;
    assign rq_push = r_wclk && rqen;

    // ------------------------------------------------------------
    // status and read data
    // ------------------------------------------------------------
    logic tq_low;
    logic rq_high;
    logic [31:0] stat;

    assign tq_low = tqen && tq_lvl < twm;
    assign rq_high = rqen && rq_lvl > rwm;

    always_comb begin
        stat = '0;
        stat[S_TDE] = s.tx_data_empty_flag;
        stat[S_TQLOW] = tq_low;
        stat[S_TUE] = s.tx_underrun_flag;
        stat[S_TFS] = s.tx_on && s.tx_slot == '0;
        stat[S_RDR] = s.rx_word_avail_flag;
        stat[S_RQHI] = rq_high;
        stat[S_ROE] = s.rx_overrun_flag;
        stat[S_RFS] = s.rx_on && s.rx_slot == '0;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        if (wr_ctrl) begin
            n.ctrl = WDATA_IN;
        end
        if (wr_cfg) begin
            n.cfg = WDATA_IN;
        end
        // software clears first so any hardware set below wins
        // write clears empty
        if (wr_hold || wr_skip) begin
            n.tx_data_empty_flag = 1'b0;
        end
        if (wr_stat && WDATA_IN[S_TUE]) begin
            n.tx_underrun_flag = 1'b0;
        end
        if (wr_stat && WDATA_IN[S_ROE]) begin
            n.rx_overrun_flag = 1'b0;
        end
        if (rd_rx) begin
            n.rx_word_avail_flag = 1'b0;
        end

        n.rdata = '0;
        if (RD_IN) begin
            case (ADDR_IN)
                OFF_CTRL: n.rdata = s.ctrl;
                OFF_STAT: n.rdata = stat;
                OFF_CFG: n.rdata = s.cfg;
                OFF_RXHOLD: n.rdata = 32'(rqen ? rq_dout : s.rx_hold);
                default: n.rdata = '0;
            endcase
        end

        // internal gated bit clock
        if (use_int) begin
            n.div = int_tick ? '0 : s.div + 1'b1;
            n.gate = gate_nx;
            if (int_tick) begin
                n.ph = !s.ph;
            end
            if (int_tick && !s.ph) begin
                n.vbit = (s.vbit == wl) ? '0 : s.vbit + 1'b1;
            end
        end else begin
            n.div = '0;
            n.gate = 1'b0;
            n.ph = 1'b0;
            n.vbit = '0;
        end
        n.bclk = n.ph && n.gate;

        // transmit path
        n.tx_fs_pend = rise.tx_fs || (s.tx_fs_pend && !t_rise);
        if (!port_en) begin
            n.tx_on = 1'b0;
            n.tx_oe = 1'b0;
            n.tx_bit = '0;
            n.tx_slot = '0;
        end else if (t_rise) begin
            n.tx_on = t_on && !gated;
            n.tx_bit = (t_idx == wl) ? '0 : t_idx + 1'b1;
            if (t_bound) begin
                if (t_frame || s.tx_slot == last_slot) begin
                    n.tx_slot = '0;
                end else begin
                    n.tx_slot = s.tx_slot + 1'b1;
                end
                n.tx_oe = tx_load;
                // a stopped transmitter keeps writes made meanwhile
                if (t_run) begin
                    n.tx_data_empty_flag = 1'b1;
                    n.tx_wr = 1'b0;
                    n.tx_skip = 1'b0;
                end
                if (t_run && !gated && !s.tx_skip
                    && (tqen ? tq_empty : !s.tx_wr)) begin
                    n.tx_underrun_flag = 1'b1;
                end
                if (tx_load) begin
                    n.tx_hold = ld_word;
                    n.tx_sh = ld_word << (WL_MAX - wl);
                end
            end else begin
                n.tx_sh = s.tx_sh << 1;
            end
        end
        // a write in the boundary cycle counts for the next slot
        if (wr_hold) begin
            n.tx_wr = 1'b1;
        end
        if (wr_hold && !tqen) begin
            n.tx_hold = WDATA_IN[DATA_W-1:0];
        end
        if (wr_skip) begin
            n.tx_skip = 1'b1;
        end

        // receive path
        n.rx_fs_pend = rise.rx_fs || (s.rx_fs_pend && !r_fall);
        if (!port_en) begin
            n.rx_on = 1'b0;
            n.rx_bit = '0;
            n.rx_slot = '0;
        end else if (r_fall) begin
            n.rx_on = r_on && !gated;
            n.rx_sh = rx_shn;
            n.rx_bit = (r_idx == wl) ? '0 : r_idx + 1'b1;
            if (r_frame) begin
                n.rx_slot = '0;
            end else if (r_idx == wl) begin
                n.rx_slot = (s.rx_slot == last_slot) ? '0 : s.rx_slot + 1'b1;
            end
            if (r_wclk && !rqen) begin
                n.rx_hold = rx_word;
                n.rx_word_avail_flag = 1'b1;
                if (s.rx_word_avail_flag && !rd_rx) begin
                    n.rx_overrun_flag = 1'b1;
                end
            end
            if (r_wclk && rqen && rq_full && !rd_rx) begin
                n.rx_overrun_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.cfg <= CFG_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PINS_OUT = {s.tx_sh[DATA_W-1], s.tx_oe, s.bclk, use_int};
    assign RDATA_OUT = s.rdata;
    assign TX_IRQ_OUT = s.ctrl[C_TIE] && (tqen ? tq_low : s.tx_data_empty_flag);
    assign RX_IRQ_OUT = s.ctrl[C_RIE] && (rqen ? rq_high : s.rx_word_avail_flag);
endmodule // ssgt_port
`default_nettype wire

/* hdl/ssgt_queue.sv */
// small word queue with level count for the tx and rx paths
`default_nettype none
`timescale 1ns/10ps
module ssgt_queue #(
    parameter int W = 16,
    parameter int DEPTH = 8,
    parameter int LW = 4
) (
    input wire logic clk_in, // system clock
    input wire logic rst_in, // sync reset, active high
    input wire logic flush_in, // empty the queue
    input wire logic push_in, // write din, dropped when full
    input wire logic pop_in, // drop head, ignored when empty
    input wire logic [W-1:0] din_in, // word to store
    output logic [W-1:0] dout_out, // head word
    output logic [LW-1:0] level_out, // words held
    output logic full_out, // no room left
    output logic empty_out // nothing held
);
    // pointers wrap by overflow, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] lvl;
    } ssgt_q_st_t;

    ssgt_q_st_t s;
    ssgt_q_st_t n;
    logic do_push;
    logic do_pop;

    assign full_out = s.lvl == LW'(DEPTH);
    assign empty_out = s.lvl == '0;
    assign do_push = push_in && !full_out;
    assign do_pop = pop_in && !empty_out;

    always_comb begin
        n = s;
        if (do_push) begin
            n.mem[s.wp] = din_in;
            n.wp = s.wp + 1'b1;
        end
        if (do_pop) begin
            n.rp = s.rp + 1'b1;
        end
        case ({do_push, do_pop})
            2'b10: n.lvl = s.lvl + 1'b1;
            2'b01: n.lvl = s.lvl - 1'b1;
            default: n.lvl = s.lvl;
        endcase
        if (flush_in) begin
            n.wp = '0;
            n.rp = '0;
            n.lvl = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dout_out = s.mem[s.rp];
    assign level_out = s.lvl;
endmodule // ssgt_queue
`default_nettype wire

/* hdl/ssgt_sync.sv */
// two-flop synchroniser with edge pulses for the port pins
`default_nettype none
`timescale 1ns/10ps
module ssgt_sync #(
    parameter int W = 5
) (
    input wire logic clk_in, // system clock
    input wire logic rst_in, // sync reset, active high
    input wire logic [W-1:0] din_in, // asynchronous pin levels
    output logic [W-1:0] lvl_out, // synchronised levels
    output logic [W-1:0] rise_out, // one-cycle rising pulse
    output logic [W-1:0] fall_out // one-cycle falling pulse
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } ssgt_sync_st_t;

    ssgt_sync_st_t s;
    ssgt_sync_st_t n;

    // s1 feeds only s2; edges look at s2 and s3
    always_comb begin
        n.s1 = din_in;
        n.s2 = s.s1;
        n.s3 = s.s2;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lvl_out = s.s2;
    assign rise_out = s.s2 & ~s.s3;
    assign fall_out = ~s.s2 & s.s3;
endmodule // ssgt_sync
`default_nettype wire

/* inc/ssgt_pkg.sv */
// constants, field layout and carrier types of the sync serial port
// Function
// - gated clock: every pulse moves one bit
// - internal gated clock idles whole word times
// - gated rx: last bit on last fall
// - rx flag: word-available, or queue above watermark
// - rx interrupt follows applicable rx flag
// - overrun when holding unread or queue full
// - gated tx pin keeps driving after word
// - tx flag: data-empty, or queue below watermark
// - tx interrupt follows applicable tx flag
// - network mode: frame sync starts each frame
// - two to thirty-two slots per frame
// - tx starts at frame after both enables
// - tx empty set each word, write clears
// - skip written tri-states slot, else load
// - nothing written: underrun, resend previous word
// - active slots shift on rise, inactive tri-state
// - tx disable after current word, pin released
// - rx starts at frame after both enables
// - sample on fall, word clock fills holding
// - word-available every slot, read clears it
// - unread word flags overrun at slot end
// - enables pick idle, rx, tx or both
`default_nettype none
package ssgt_pkg;
    localparam int DATA_W = 16;
    localparam int BCNT_W = 4;
    localparam int SLOT_W = 5;
    localparam int QDEPTH = 8;
    localparam int QLVL_W = 4;
    localparam int DIV_W = 8;
    localparam int PIN_W = 5;
    // register byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_TXHOLD = 8'h08;
    localparam logic [7:0] OFF_TXSKIP = 8'h0C;
    localparam logic [7:0] OFF_RXHOLD = 8'h10;
    localparam logic [7:0] OFF_CFG = 8'h14;
    // port control word fields
    localparam int C_PORT = 0;
    localparam int C_TXEN = 1;
    localparam int C_RXEN = 2;
    localparam int C_GATED = 3;
    localparam int C_INTCLK = 4;
    localparam int C_TIE = 5;
    localparam int C_RIE = 6;
    localparam int C_TQEN = 7;
    localparam int C_RQEN = 8;
    localparam int C_SLOTS = 16;
    localparam int C_WL = 24;
    // configuration word fields
    localparam int F_TXWM = 0;
    localparam int F_RXWM = 8;
    localparam int F_DIV = 16;
    // port status word bits
    localparam int S_TDE = 0;
    localparam int S_TQLOW = 1;
    localparam int S_TUE = 2;
    localparam int S_TFS = 3;
    localparam int S_RDR = 4;
    localparam int S_RQHI = 5;
    localparam int S_ROE = 6;
    localparam int S_RFS = 7;
    localparam logic [31:0] CTRL_RST = 32'h0F01_0000;
    localparam logic [31:0] CFG_RST = 32'h0004_0404;
    localparam logic [SLOT_W-1:0] SLOT_MIN = 5'h01;
    localparam logic [BCNT_W-1:0] WL_MAX = 4'hF;

    typedef struct packed {
        logic tx_bclk;
        logic tx_fs;
        logic rx_bclk;
        logic rx_fs;
        logic rx_data;
    } ssgt_pin_in_t;

    typedef struct packed {
        logic tx_data;
        logic tx_data_oe;
        logic tx_bclk;
        logic tx_bclk_oe;
    } ssgt_pin_out_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic [DATA_W-1:0] tx_hold;
        logic [DATA_W-1:0] tx_sh;
        logic [DATA_W-1:0] rx_sh;
        logic [DATA_W-1:0] rx_hold;
        logic [BCNT_W-1:0] tx_bit;
        logic [BCNT_W-1:0] rx_bit;
        logic [BCNT_W-1:0] vbit;
        logic [SLOT_W-1:0] tx_slot;
        logic [SLOT_W-1:0] rx_slot;
        logic [DIV_W-1:0] div;
        logic tx_on;
        logic tx_oe;
        logic tx_wr;
        logic tx_skip;
        logic tx_data_empty_flag;
        logic tx_underrun_flag;
        logic tx_fs_pend;
        logic rx_on;
        logic rx_word_avail_flag;
        logic rx_overrun_flag;
        logic rx_fs_pend;
        logic ph;
        logic gate;
        logic bclk;
    } ssgt_state_t;
endpackage
`default_nettype wire

/* test/ssgt_codec.sv */
// behavioural tdm codec: free bit clock, frame sync, rx data, tx capture
`timescale 1ns/10ps
`default_nettype none
module ssgt_codec #(
    parameter int BITS = 8, // bits per slot
    parameter int SLOTS = 2 // slots per frame
) (
    input wire logic [BITS-1:0] word_in, // sent in every slot
    input wire ssgt_pkg::ssgt_pin_out_t port_in, // port pins
    output var ssgt_pkg::ssgt_pin_in_t pins_out, // clocks, syncs, data
    output var logic [BITS-1:0] word_out, // last slot word from port
    output var logic oe_out, // port drove last slot
    output var int slot_cnt_out // slots seen
);
    // ------------------------------------------
    // bus timing
    // ------------------------------------------
    logic ck = 1'b0;
    int n = 0;
    logic [BITS-1:0] sh = '0;
    initial begin
        pins_out = '0;
        word_out = '0;
        oe_out = 1'b0;
        slot_cnt_out = 0;
    end
    always #80 ck = ~ck;
    // tx bits sampled one rise late, port output lags
    always @(posedge ck) begin
        pins_out.tx_bclk <= 1'b1;
        pins_out.rx_bclk <= 1'b1;
        sh <= {sh[BITS-2:0], port_in.tx_data};
        if (n % BITS == 0) begin
            word_out <= {sh[BITS-2:0], port_in.tx_data};
            oe_out <= port_in.tx_data_oe;
            slot_cnt_out <= slot_cnt_out + 1;
        end
        pins_out.rx_data <= word_in[BITS-1-(n % BITS)];
        n <= (n + 1) % (BITS * SLOTS);
    end
    // frame sync rises before bit 0 of slot 0
    always @(negedge ck) begin
        pins_out.tx_bclk <= 1'b0;
        pins_out.rx_bclk <= 1'b0;
        pins_out.tx_fs <= (n == 0);
        pins_out.rx_fs <= (n == 0);
    end
endmodule // ssgt_codec
`default_nettype wire

/* test/ssgt_props.sv */
// checker of register and pin relations of the serial port
`timescale 1ns/10ps
`default_nettype none
module ssgt_props (
    input wire logic REF_CLK_IN, // clock
    input wire logic RST_IN, // reset
    input wire ssgt_pkg::ssgt_pin_in_t PINS_IN, // pins in
    input wire ssgt_pkg::ssgt_pin_out_t PINS_OUT, // pins out
    input wire logic [7:0] ADDR_IN, // address
    input wire logic [31:0] WDATA_IN, // write data
    input wire logic WR_IN, // write strobe
    input wire logic RD_IN, // read strobe
    input wire logic [31:0] RDATA_OUT, // read data
    input wire logic TX_IRQ_OUT, // tx irq
    input wire logic RX_IRQ_OUT // rx irq
);
    import ssgt_pkg::*;
    // ------------------------------------------
    // control shadow and properties
    // ------------------------------------------
    logic [31:0] ctrl_ff;
    logic wr_tx;
    logic rd_rx;
    logic rd_st;
    logic rx_chk;
    logic tx_chk;
    assign wr_tx = WR_IN && (ADDR_IN == OFF_TXHOLD || ADDR_IN == OFF_TXSKIP);
    assign rd_rx = RD_IN && ADDR_IN == OFF_RXHOLD;
    assign rd_st = RD_IN && ADDR_IN == OFF_STAT;
    // only the plain flag paths tie status bits to the irq lines
    assign rx_chk = rd_st && ctrl_ff[C_RIE] && !ctrl_ff[C_RQEN];
    assign tx_chk = rd_st && ctrl_ff[C_TIE] && !ctrl_ff[C_TQEN];
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ctrl_ff <= CTRL_RST;
        end else if (WR_IN && ADDR_IN == OFF_CTRL) begin
            ctrl_ff <= WDATA_IN;
        end
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    a_tx_write_clear: assert property (
        wr_tx && !ctrl_ff[C_GATED] && !ctrl_ff[C_TQEN] |=> !TX_IRQ_OUT)
        else $error("tx irq held after holding write");
    a_rx_read_clear: assert property (
        rd_rx && !ctrl_ff[C_RQEN] |=> !RX_IRQ_OUT)
        else $error("rx irq held after holding read");
    a_rx_flag_irq: assert property (
        $past(rx_chk) |-> RDATA_OUT[S_RDR] == $past(RX_IRQ_OUT))
        else $error("rx irq differs from word flag");
    a_tx_flag_irq: assert property (
        $past(tx_chk) |-> RDATA_OUT[S_TDE] == $past(TX_IRQ_OUT))
        else $error("tx irq differs from empty flag");
    a_tx_pin_release: assert property (
        $fell(ctrl_ff[C_TXEN]) |-> ##[1:300] !PINS_OUT.tx_data_oe)
        else $error("tx pin still driven after disable");
    a_bclk_drive_sel: assert property (
        PINS_OUT.tx_bclk_oe == (ctrl_ff[C_GATED] && ctrl_ff[C_INTCLK]))
        else $error("bit clock drive mismatch");
    a_gated_irq_apart: assert property (
        ctrl_ff[C_GATED] |-> !($rose(TX_IRQ_OUT) && $rose(RX_IRQ_OUT)))
        else $error("tx and rx irq rose together");
    a_rx_word_mask: assert property (
        $past(rd_rx) |->
        (RDATA_OUT >> (ctrl_ff[C_WL +: 4] + 5'h01)) == 32'h0)
        else $error("rx word bits above length");
    c_tx_irq: cover property ($rose(TX_IRQ_OUT));
    c_rx_irq: cover property ($rose(RX_IRQ_OUT));
    c_oe_drop: cover property ($fell(PINS_OUT.tx_data_oe));
endmodule // ssgt_props
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the port in network slot mode and gated queue mode
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ssgt_pkg::*;
    // ------------------------------------------
    // bench signals and tasks
    // ------------------------------------------
    localparam logic [31:0] NET_CTRL = 32'h0701_0067;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic tx_irq;
    logic rx_irq;
    ssgt_pin_in_t pins_in;
    ssgt_pin_out_t pins_out;
    logic [7:0] tx_word;
    logic tx_oe;
    int slot_cnt;
    int mismatches = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    ssgt_port DUT (.REF_CLK_IN(clk), .RST_IN(rst), .PINS_IN(pins_in),
        .PINS_OUT(pins_out), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .TX_IRQ_OUT(tx_irq),
        .RX_IRQ_OUT(rx_irq));
    ssgt_codec #(.BITS(8), .SLOTS(2)) u_codec (.word_in(8'h3C),
        .port_in(pins_out), .pins_out(pins_in), .word_out(tx_word),
        .oe_out(tx_oe), .slot_cnt_out(slot_cnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask
    // waits for the codec to see a new slot, then for the port to settle
    task automatic next_slot();
        int s;
        s = slot_cnt;
        for (int i = 0; i < 400 && slot_cnt == s; i++)
            @(posedge clk);
        if (slot_cnt == s) begin
            mismatches++;
            $display("MISMATCH %0t slot timeout", $time);
        end
        repeat (20) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFF_CTRL, '1, CTRL_RST);
        rd_reg(OFF_STAT, '1, 32'h0);
        rd_reg(8'h18, '1, 32'h0);
        $display("test reset done");
        wr_reg(OFF_TXHOLD, 32'h0000_00A5);
        wr_reg(OFF_CTRL, NET_CTRL);
        for (int i = 0; i < 8 && tx_oe !== 1'b1; i++)
            next_slot();
        chk(tx_word, 32'hA5);
        chk(tx_irq, 1'b1);
        wr_reg(OFF_TXHOLD, 32'h0000_005A);
        #1 chk(tx_irq, 1'b0);
        next_slot();
        wr_reg(OFF_STAT, 32'h0000_0004);
        rd_reg(OFF_STAT, 32'h0000_0004, 32'h0);
        next_slot();
        chk(tx_word, 32'h5A);
        rd_reg(OFF_STAT, 32'h0000_0004, 32'h0000_0004);
        wr_reg(OFF_TXSKIP, 32'h0);
        next_slot();
        wr_reg(OFF_TXHOLD, 32'h0000_0096);
        next_slot();
        chk(tx_oe, 1'b0);
        next_slot();
        chk(tx_word, 32'h96);
        chk(tx_oe, 1'b1);
        $display("test network transmit done");
        rd_reg(OFF_STAT, 32'h0000_0050, 32'h0000_0050);
        chk(rx_irq, 1'b1);
        rd_reg(OFF_RXHOLD, '1, 32'h0000_003C);
        chk(rx_irq, 1'b0);
        wr_reg(OFF_STAT, 32'h0000_0040);
        for (int i = 0; i < 2; i++) begin
            next_slot();
            rd_reg(OFF_RXHOLD, '1, 32'h0000_003C);
        end
        rd_reg(OFF_STAT, 32'h0000_0040, 32'h0);
        $display("test network receive done");
        wr_reg(OFF_CTRL, 32'h0701_0065);
        next_slot();
        next_slot();
        chk(tx_oe, 1'b0);
        chk(pins_out.tx_data_oe, 1'b0);
        $display("test disable done");
        wr_reg(OFF_CTRL, 32'h0701_016F);
        wr_reg(OFF_TXHOLD, 32'h0000_00C3);
        repeat (6) next_slot();
        chk(tx_word, 32'hC3);
        chk(tx_oe, 1'b1);
        rd_reg(OFF_STAT, 32'h0000_0020, 32'h0000_0020);
        rd_reg(OFF_RXHOLD, '1, 32'h0000_003C);
        $display("test gated queue done");
        finish_test();
    end
endmodule // tb_top
bind ssgt_port ssgt_props u_props (.REF_CLK_IN(REF_CLK_IN),
    .RST_IN(RST_IN), .PINS_IN(PINS_IN), .PINS_OUT(PINS_OUT),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .TX_IRQ_OUT(TX_IRQ_OUT), .RX_IRQ_OUT(RX_IRQ_OUT));
`default_nettype wire
